// ===== pmi2c_pkg.sv
`default_nettype none
package pmi2c_pkg;
   // ****************************************
   // register map
   // ****************************************
   localparam logic [2:0] REG_SHUNT_HI  = 3'h0;
   localparam logic [2:0] REG_SHUNT_LO  = 3'h1;
   localparam logic [2:0] REG_SUPPLY_HI = 3'h2;
   localparam logic [2:0] REG_SUPPLY_LO = 3'h3;
   localparam logic [2:0] REG_AUX_HI    = 3'h4;
   localparam logic [2:0] REG_AUX_LO    = 3'h5;
   localparam logic [2:0] REG_CONTROL   = 3'h6;
   localparam logic [2:0] REG_RESERVED  = 3'h7;
   localparam logic [2:0] PTR_RESET     = 3'h0;
   localparam logic [2:0] PTR_LAST      = 3'h6;
   // control fields and reset value: page and stuck timer enabled
   localparam int         CTL_STUCK_BIT = 2;
   localparam int         CTL_PAGE_BIT  = 3;
   localparam int         CTL_TEST_BIT  = 4;
   localparam logic [7:0] CTL_RESET     = 8'h0C;
   localparam logic [7:0] CTL_WMASK     = 8'hFC;
   localparam logic [7:0] LO_DATA_MASK  = 8'hF0;
   localparam int         LO_BUSY_BIT   = 3;
   // ****************************************
   // addressing
   // ****************************************
   localparam logic [2:0] ADDR_FIXED    = 3'h6;
   localparam logic [6:0] ADDR_BCAST    = 7'h66;
   // three-level strap codes
   localparam logic [1:0] STRAP_LOW     = 2'h0;
   localparam logic [1:0] STRAP_HIGH    = 2'h1;
   localparam logic [1:0] STRAP_OPEN    = 2'h2;
   // ****************************************
   // timing
   // ****************************************
   localparam int         CLK_MHZ       = 250;
   localparam int         STUCK_MS      = 33;
   localparam int         STUCK_CYCLES  = STUCK_MS * 1000 * CLK_MHZ;
   localparam int         BIT_CNT_W     = 4;
   localparam logic [3:0] BIT_LAST      = 4'h7;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_ADDR  = 3'b001,
      ST_ACK   = 3'b010,
      ST_RX    = 3'b011,
      ST_TX    = 3'b100,
      ST_RACK  = 3'b101,
      ST_WAIT  = 3'b110
   } pmi2c_state_t;
endpackage
`default_nettype wire

// ===== pmi2c_sync.sv
`default_nettype none
// ****************************************
// three-stage input synchroniser
// ****************************************
module pmi2c_sync
   import pmi2c_pkg::*;
(
   input  wire logic ref_clk_i,
   input  wire logic srst_i,
   input  wire logic async_i,
   output logic      level_o
);
   logic [2:0] sh_q;
   logic [2:0] sh_d;
   logic       lvl_q;
   logic       lvl_d;

   // stage 0 only feeds stage 1; a change counts once 1 and 2 agree
   always_comb
   begin
      sh_d  = {sh_q[1:0], async_i};
      lvl_d = (sh_q[1] == sh_q[2]) ? sh_q[2] : lvl_q;
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (srst_i)
      begin
         sh_q  <= 3'h7;
         lvl_q <= 1'b1;
      end
      else
      begin
         sh_q  <= sh_d;
         lvl_q <= lvl_d;
      end
   end

   assign level_o = lvl_q;
endmodule
`default_nettype wire

// ===== pmi2c_stuck.sv
`default_nettype none
// ****************************************
// stuck-bus timer
// ****************************************
module pmi2c_stuck
   import pmi2c_pkg::*;
#(
   parameter int STUCK_LIMIT = STUCK_CYCLES
)
(
   input  wire logic ref_clk_i,
   input  wire logic srst_i,
   input  wire logic enable_i,
   input  wire logic scl_i,
   input  wire logic sda_i,
   output logic      expire_o
);
   logic [23:0] cnt_q;
   logic [23:0] cnt_d;
   logic        exp_q;
   logic        exp_d;

   always_comb
   begin
      cnt_d = cnt_q;
      exp_d = 1'b0;
      if (!enable_i)
         cnt_d = '0;
      else if (scl_i && sda_i)
         cnt_d = '0;
      else if (cnt_q >= 24'(STUCK_LIMIT))
      begin
         exp_d = 1'b1;
         cnt_d = '0;
      end
      else
         cnt_d = cnt_q + 24'h000001;
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (srst_i)
      begin
         cnt_q <= '0;
         exp_q <= 1'b0;
      end
      else
      begin
         cnt_q <= cnt_d;
         exp_q <= exp_d;
      end
   end

   assign expire_o = exp_q;

   // ****************************************
   // checks
   // ****************************************
   // disabled timer never fires
   AST_STUCK_DISABLED: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      !enable_i |=> !expire_o)
      else $error("stuck timer fired while disabled");
   AST_STUCK_IDLE: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      (scl_i && sda_i) |=> !expire_o)
      else $error("stuck timer fired with bus idle");
endmodule
`default_nettype wire

// ===== pmi2c_slave.sv
`default_nettype none
// What this block does
// - stuck timer runs while a line is low, clears when both high
// - a line low beyond 33 ms resets the bus state machine
// - stuck timer runs only while its control enable bit is set
// - address bits 6..4 are 110, 3..0 from straps, eighth bit read/write
// - strap pair maps to address bits 3..0 by the nine-entry table
// - broadcast address 1100110 accepted for writes regardless of straps
// - device pulls data low on ninth clock to acknowledge address and bytes
// - sender releases data during the acknowledge clock
// - command byte low three bits load the pointer, upper bits ignored
// - written bytes store at pointer, pointer advances after each
// - any stop ends the transfer and resets pointer to 00h
// - data registers writable only while test-write enable is set
// - 12-bit value: eight MSBs high register, four LSBs low bits 7:4
// - low register bit 3 shows channel busy, not writable
// - low register bits 2:0 read zero, ignore writes
// - split data input pin and output pin, output optionally inverted
// - pointer wraps from 06h to 00h
// - page transfers unsupported when page enable is clear
// - test-write enable blocks converter updates of data registers
module pmi2c_slave
   import pmi2c_pkg::*;
#(
   parameter int   STUCK_LIMIT = STUCK_CYCLES,
   parameter logic INVERT_OUT  = 1'b0
)
(
   input  wire logic       ref_clk_i,
   input  wire logic       srst_i,
   input  wire logic       scl_i,
   input  wire logic       split_data_in_i,
   output logic            split_data_out_o,
   output logic            sda_oe_o,
   input  wire logic [1:0] addr_strap_high_i,
   input  wire logic [1:0] addr_strap_low_i,
   input  wire logic       conv_we_i,
   input  wire logic [2:0] conv_chan_i,
   input  wire logic [11:0] conv_data_i,
   input  wire logic [2:0] conv_busy_i,
   output logic [7:0]      control_o
);
   // ****************************************
   // pin sampling and bus events
   // ****************************************
   logic scl_s;
   logic sda_s;
   logic scl_p_q;
   logic sda_p_q;
   logic stuck_exp;

   pmi2c_sync u_sync_scl (
      .ref_clk_i (ref_clk_i),
      .srst_i    (srst_i),
      .async_i   (scl_i),
      .level_o   (scl_s)
   );
   pmi2c_sync u_sync_sda (
      .ref_clk_i (ref_clk_i),
      .srst_i    (srst_i),
      .async_i   (split_data_in_i),
      .level_o   (sda_s)
   );

   logic [7:0] ctl_q;
   logic [7:0] ctl_d;

   pmi2c_stuck #(.STUCK_LIMIT(STUCK_LIMIT)) u_stuck (
      .ref_clk_i (ref_clk_i),
      .srst_i    (srst_i),
      .enable_i  (ctl_q[CTL_STUCK_BIT]),
      .scl_i     (scl_s),
      .sda_i     (sda_s),
      .expire_o  (stuck_exp)
   );

   always_ff @(posedge ref_clk_i)
   begin
      if (srst_i)
      begin
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
      end
      else
      begin
         scl_p_q <= scl_s;
         sda_p_q <= sda_s;
      end
   end

   logic scl_rise;
   logic scl_fall;
   logic start_ev;
   logic stop_ev;
   assign scl_rise = scl_s && !scl_p_q;
   assign scl_fall = !scl_s && scl_p_q;
   assign start_ev = scl_s && scl_p_q && sda_p_q && !sda_s;
   assign stop_ev  = scl_s && scl_p_q && !sda_p_q && sda_s;

   // ****************************************
   // own address from straps
   // ****************************************
   logic [3:0] strap_addr;
   always_comb
   begin
      unique case ({addr_strap_high_i, addr_strap_low_i})
         {STRAP_HIGH, STRAP_LOW}:  strap_addr = 4'h7;
         {STRAP_OPEN, STRAP_HIGH}: strap_addr = 4'h8;
         {STRAP_HIGH, STRAP_HIGH}: strap_addr = 4'h9;
         {STRAP_OPEN, STRAP_OPEN}: strap_addr = 4'hA;
         {STRAP_OPEN, STRAP_LOW}:  strap_addr = 4'hB;
         {STRAP_LOW, STRAP_HIGH}:  strap_addr = 4'hC;
         {STRAP_HIGH, STRAP_OPEN}: strap_addr = 4'hD;
         {STRAP_LOW, STRAP_OPEN}:  strap_addr = 4'hE;
         {STRAP_LOW, STRAP_LOW}:   strap_addr = 4'hF;
         default:                  strap_addr = 4'hA;
      endcase
   end

   // ****************************************
   // register bank
   // ****************************************
   logic [7:0] data_q [6];
   logic [7:0] data_d [6];
   logic [7:0] rd_byte;
   logic       wr_en;
   logic [2:0] wr_ptr;
   logic [7:0] wr_byte;
   logic       test_en;
   assign test_en   = ctl_q[CTL_TEST_BIT];
   assign control_o = ctl_q;

   genvar gi;
   generate
      for (gi = 0; gi < 6; gi++)
      begin : g_reg
         always_comb
         begin
            data_d[gi] = data_q[gi];
            // converter update only outside test mode
            if (!test_en && conv_we_i && conv_chan_i == 3'(gi / 2))
               data_d[gi] = (gi % 2 == 0) ? conv_data_i[11:4] :
                            {conv_data_i[3:0], 4'h0};
            // bus writes only in test mode
            else if (test_en && wr_en && wr_ptr == 3'(gi))
               data_d[gi] = (gi % 2 == 0) ? wr_byte : (wr_byte & LO_DATA_MASK);
         end
         always_ff @(posedge ref_clk_i)
         begin
            if (srst_i)
               data_q[gi] <= 8'h00;
            else
               data_q[gi] <= data_d[gi];
         end
      end
   endgenerate

   always_comb
   begin
      ctl_d = ctl_q;
      if (wr_en && wr_ptr == REG_CONTROL)
         ctl_d = wr_byte & CTL_WMASK;
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (srst_i)
         ctl_q <= CTL_RESET;
      else
         ctl_q <= ctl_d;
   end

   function automatic logic [7:0] read_reg(input logic [2:0] p);
      logic [7:0] r;
      r = 8'h00;
      // low register layout with busy flag
      if (p < REG_CONTROL)
      begin
         r = data_q[p];
         if (p[0])
         begin
            r = data_q[p] & LO_DATA_MASK;
            r[LO_BUSY_BIT] = conv_busy_i[p[2:1]];
         end
      end
      else if (p == REG_CONTROL)
         r = ctl_q;
      return r;
   endfunction

   // ****************************************
   // bus state machine
   // ****************************************
   pmi2c_state_t st_q, st_d;
   logic [7:0]   sh_q, sh_d;
   logic [3:0]   bit_q, bit_d;
   logic [2:0]   ptr_q, ptr_d;
   logic         rw_q, rw_d;
   logic         cmd_q, cmd_d;
   logic         first_q, first_d;
   logic         oe_q, oe_d;
   logic         ack_ok;
   logic [6:0]   rx_addr;

   assign rx_addr = sh_q[7:1];

   always_comb
   begin
      st_d    = st_q;
      sh_d    = sh_q;
      bit_d   = bit_q;
      ptr_d   = ptr_q;
      rw_d    = rw_q;
      cmd_d   = cmd_q;
      first_d = first_q;
      oe_d    = oe_q;
      wr_en   = 1'b0;
      wr_ptr  = ptr_q;
      wr_byte = sh_q;
      ack_ok  = 1'b0;
      if (stop_ev || stuck_exp)
      begin
         st_d  = ST_IDLE;
         ptr_d = PTR_RESET;
         oe_d  = 1'b0;
      end
      else if (start_ev)
      begin
         st_d  = ST_ADDR;
         bit_d = '0;
         oe_d  = 1'b0;
      end
      else
      begin
         unique case (st_q)
            ST_IDLE, ST_WAIT: ;
            ST_ADDR, ST_RX:
            begin
               if (scl_rise)
               begin
                  sh_d  = {sh_q[6:0], sda_s};
                  bit_d = bit_q + 4'h1;
               end
               if (scl_fall && bit_q == BIT_LAST + 4'h1)
               begin
                  bit_d = '0;
                  if (st_q == ST_ADDR)
                  begin
                     ack_ok = (rx_addr == {ADDR_FIXED, strap_addr}) ||
                              (rx_addr == ADDR_BCAST && !sh_q[0]);
                     rw_d    = sh_q[0];
                     cmd_d   = !sh_q[0];
                     first_d = 1'b1;
                  end
                  else if (cmd_q)
                  begin
                     ack_ok = 1'b1;
                     ptr_d  = sh_q[2:0];
                     cmd_d  = 1'b0;
                  end
                  else
                  begin
                     ack_ok = first_q || ctl_q[CTL_PAGE_BIT];
                     wr_en   = ack_ok;
                     first_d = 1'b0;
                     ptr_d = (ptr_q >= PTR_LAST) ? PTR_RESET : ptr_q + 3'h1;
                  end
                  oe_d = ack_ok;
                  st_d = ack_ok ? ST_ACK : ST_WAIT;
               end
            end
            ST_ACK:
            begin
               if (scl_fall)
               begin
                  if (rw_q)
                  begin
                     sh_d = read_reg(ptr_q);
                     st_d = ST_TX;
                     oe_d = !sh_d[7];
                  end
                  else
                  begin
                     oe_d = 1'b0;
                     st_d = ST_RX;
                  end
               end
            end
            ST_TX:
            begin
               if (scl_fall)
               begin
                  bit_d = bit_q + 4'h1;
                  sh_d  = {sh_q[6:0], 1'b0};
                  oe_d  = (bit_q == BIT_LAST) ? 1'b0 : !sh_q[6];
                  if (bit_q == BIT_LAST)
                  begin
                     st_d  = ST_RACK;
                     bit_d = '0;
                     ptr_d = (ptr_q >= PTR_LAST) ? PTR_RESET : ptr_q + 3'h1;
                  end
               end
            end
            ST_RACK:
            begin
               // master ack continues only when page enable is set; nack, or ack with page clear, waits for stop
               if (scl_rise)
                  st_d = (!sda_s && ctl_q[CTL_PAGE_BIT]) ? ST_ACK : ST_WAIT;
            end
            default: st_d = ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (srst_i)
      begin
         st_q    <= ST_IDLE;
         sh_q    <= 8'h00;
         bit_q   <= '0;
         ptr_q   <= PTR_RESET;
         rw_q    <= 1'b0;
         cmd_q   <= 1'b0;
         first_q <= 1'b0;
         oe_q    <= 1'b0;
      end
      else
      begin
         st_q    <= st_d;
         sh_q    <= sh_d;
         bit_q   <= bit_d;
         ptr_q   <= ptr_d;
         rw_q    <= rw_d;
         cmd_q   <= cmd_d;
         first_q <= first_d;
         oe_q    <= oe_d;
      end
   end

   // split output, optional inversion; oe pulls line low
   assign sda_oe_o         = oe_q;
   assign split_data_out_o = INVERT_OUT ? oe_q : !oe_q;

   // ****************************************
   // checks
   // ****************************************
   // pointer cleared after stop
   AST_STOP_PTR: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      stop_ev |=> (ptr_q == PTR_RESET && st_q == ST_IDLE))
      else $error("pointer not reset by stop");
   // pointer wraps after the last register
   AST_PTR_RANGE: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      (st_q == ST_TX && scl_fall && bit_q == BIT_LAST && ptr_q == PTR_LAST
       && !stop_ev && !start_ev && !stuck_exp) |=> ptr_q == PTR_RESET)
      else $error("pointer did not wrap after the last register");
   // data register 0 stays without test mode unless converter writes
   AST_RO_DATA: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      (!test_en && !conv_we_i) |=> data_q[0] == $past(data_q[0]))
      else $error("data register changed without test mode");
   // low bits of stored low register zero
   AST_LOW_ZERO: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      data_q[1][3:0] == 4'h0)
      else $error("low register reserved bits set");
   AST_STUCK_RST: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      stuck_exp |=> (st_q == ST_IDLE && !sda_oe_o))
      else $error("stuck expiry did not reset");
   AST_RX_RELEASE: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      (st_q == ST_RX || st_q == ST_ADDR) |-> !sda_oe_o)
      else $error("device drives line while receiving");
   AST_ACK_HOLD: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      (st_q == ST_ACK && !rw_q) |-> sda_oe_o)
      else $error("acknowledge not driven");
   AST_CMD_PTR: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      (st_q == ST_RX && cmd_q && scl_fall && bit_q == BIT_LAST + 4'h1
       && !stop_ev && !start_ev && !stuck_exp) |=> ptr_q == $past(sh_q[2:0]))
      else $error("command did not load pointer");
endmodule
`default_nettype wire

// ===== pmi2c_master_model.sv
`default_nettype none
// ****
// two-wire master model
// ****
module pmi2c_master_model
(
   input  wire logic  ref_clk_i,
   input  wire logic  sda_i,
   output logic       scl_o,
   output logic       sda_pull_o,
   output logic [7:0] res_o
);
   timeunit 1ns;
   timeprecision 1ps;
   event got;
   initial
   begin
      scl_o = 1'b1;
      sda_pull_o = 1'b0;
      res_o = 8'h00;
   end
   task automatic w(input int n);
      repeat (n) @(negedge ref_clk_i);
   endtask
   // ****
   // bus cycles, 16 cycles a bit
   // ****
   // data moves 2 cycles after the clock falls so it never looks like a start
   task automatic bitx(input logic b, output logic r);
      w(2);
      sda_pull_o = ~b;
      w(6);
      scl_o = 1'b1;
      w(4);
      r = sda_i;
      w(4);
      scl_o = 1'b0;
   endtask
   task automatic start();
      w(2);
      sda_pull_o = 1'b0;
      w(6);
      scl_o = 1'b1;
      w(8);
      sda_pull_o = 1'b1;
      w(8);
      scl_o = 1'b0;
   endtask
   task automatic stop();
      w(2);
      sda_pull_o = 1'b1;
      w(6);
      scl_o = 1'b1;
      w(8);
      sda_pull_o = 1'b0;
      w(8);
   endtask
   task automatic wr(input logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--)
         bitx(d[i], r);
      bitx(1'b1, r);
      res_o = {7'h00, r};
      -> got;
   endtask
   task automatic rd(input logic nak);
      logic [7:0] d;
      logic       r;
      for (int i = 7; i >= 0; i--)
         bitx(1'b1, d[i]);
      bitx(nak, r);
      res_o = d;
      -> got;
   endtask
   task automatic peek(input int n);
      w(n);
      res_o = {7'h00, sda_i};
      -> got;
   endtask
endmodule
`default_nettype wire

// ===== test_i2c_monitor_register_slave.sv
`default_nettype none
module test_i2c_monitor_register_slave
   import pmi2c_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   // short stuck limit keeps the hang test quick, yet it outlasts the
   // longest legal low run on the data line (a long read of zeros)
   localparam int LIMIT = 1500;
   localparam logic [7:0] ST [9] = '{8'h47, 8'h98, 8'h59, 8'hAA, 8'h8B, 8'h1C, 8'h6D,
                                     8'h2E, 8'h0F};
   logic        ref_clk = 1'b0;
   logic        srst = 1'b1;
   logic        scl, pull, sda, s_out;
   logic        oe;
   logic [7:0]  ctl;
   logic [1:0]  st_hi = 2'h1;
   logic [1:0]  st_lo = 2'h0;
   logic        conv_we = 1'b0;
   logic [2:0]  conv_chan = 3'h0;
   logic [2:0]  busy = 3'h0;
   logic [11:0] conv_data = 12'h000;
   logic [7:0]  exp_r [8];
   logic [7:0]  exp_q [$];
   logic [7:0]  e;
   logic [6:0]  dev = 7'h67;
   int          seed = 32'hDED4;
   int          failures = 0;
   int          compares = 0;
   int          cycles = 0;
   // output returned to the input, open drain with pull-up
   assign sda = ~pull & s_out;
   pmi2c_slave #(.STUCK_LIMIT(LIMIT), .INVERT_OUT(1'b0)) dut (
      .ref_clk_i(ref_clk), .srst_i(srst), .scl_i(scl), .split_data_in_i(sda),
      .split_data_out_o(s_out), .sda_oe_o(oe), .addr_strap_high_i(st_hi),
      .addr_strap_low_i(st_lo), .conv_we_i(conv_we), .conv_chan_i(conv_chan),
      .conv_data_i(conv_data), .conv_busy_i(busy), .control_o(ctl));
   pmi2c_master_model m (.ref_clk_i(ref_clk), .sda_i(sda), .scl_o(scl),
      .sda_pull_o(pull), .res_o());
   always #2 ref_clk = ~ref_clk;
   // ****
   // helpers
   // ****
   task automatic report_and_stop();
      failures += exp_q.size();
      $display("failures %0d compares %0d", failures, compares);
      if (failures == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic note(input logic [7:0] v);
      exp_q.push_back(v);
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] want);
      compares++;
      if (got !== want)
      begin
         $display("wrong value at %0t: got %h expected %h", $time, got, want);
         failures++;
      end
   endtask
   task automatic adr(input logic [6:0] a, input logic rw, input logic nak);
      m.start();
      note({7'h00, nak});
      m.wr({a, rw});
   endtask
   task automatic wb(input logic [7:0] b, input logic nak);
      note({7'h00, nak});
      m.wr(b);
   endtask
   function automatic logic [7:0] rexp(input logic [2:0] p);
      rexp = exp_r[p];
      if (p < REG_CONTROL && p[0])
         rexp[LO_BUSY_BIT] = busy[p >> 1];
   endfunction
   task automatic put(input logic [2:0] p, input logic [7:0] d);
      if (p == REG_CONTROL)
         exp_r[p] = d & CTL_WMASK;
      else if (p < REG_CONTROL && exp_r[REG_CONTROL][CTL_TEST_BIT])
         exp_r[p] = p[0] ? (d & LO_DATA_MASK) : d;
   endtask
   task automatic wpage(input logic [6:0] a, input logic [7:0] cmd, input int n,
                        input logic [7:0] first);
      logic [7:0] d;
      logic [2:0] p;
      logic       nak;
      adr(a, 1'b0, 1'b0);
      wb(cmd, 1'b0);
      p = cmd[2:0];
      for (int i = 0; i < n; i++)
      begin
         d = (i == 0) ? first : 8'($random(seed));
         nak = i > 0 && !exp_r[REG_CONTROL][CTL_PAGE_BIT];
         wb(d, nak);
         if (!nak)
            put(p, d);
         p = (p >= PTR_LAST) ? PTR_RESET : p + 3'h1;
      end
      m.stop();
      chk(ctl, exp_r[REG_CONTROL]);
   endtask
   task automatic rpage(input logic [7:0] cmd, input int n);
      logic [2:0] p;
      adr(dev, 1'b0, 1'b0);
      wb(cmd, 1'b0);
      adr(dev, 1'b1, 1'b0);
      p = cmd[2:0];
      for (int i = 0; i < n; i++)
      begin
         note((i > 0 && !exp_r[REG_CONTROL][CTL_PAGE_BIT]) ? 8'hFF : rexp(p));
         m.rd(i == n - 1);
         p = (p >= PTR_LAST) ? PTR_RESET : p + 3'h1;
      end
      m.stop();
   endtask
   // clock held low while the device drives a zero; rel is the expected line
   task automatic stuck(input logic rel);
      adr(dev, 1'b0, 1'b0);
      wb(8'h06, 1'b0);
      adr(dev, 1'b1, 1'b0);
      note({7'h00, rel});
      m.peek(1800);
      chk({7'h00, oe}, {7'h00, !rel});
      if (!rel)
      begin
         note(exp_r[REG_CONTROL]);
         m.rd(1'b1);
      end
      m.stop();
   endtask
   task automatic conv(input logic [2:0] c);
      logic [11:0] d;
      d = 12'($random(seed));
      @(negedge ref_clk);
      conv_chan = c;
      conv_data = d;
      conv_we = 1'b1;
      @(negedge ref_clk);
      conv_we = 1'b0;
      if (!exp_r[REG_CONTROL][CTL_TEST_BIT])
      begin
         exp_r[{c[1:0], 1'b0}] = d[11:4];
         exp_r[{c[1:0], 1'b1}] = {d[3:0], 4'h0};
      end
   endtask
   // ****
   // watcher and sequence
   // ****
   always @(m.got)
   begin
      e = (exp_q.size() != 0) ? exp_q.pop_front() : 8'hXX;
      compares++;
      if (m.res_o !== e)
      begin
         $display("wrong value at %0t: got %h expected %h", $time, m.res_o, e);
         failures++;
      end
   end
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 90000)
      begin
         failures++;
         report_and_stop();
      end
   end
   initial
   begin
      exp_r = '{8{8'h00}};
      exp_r[REG_CONTROL] = CTL_RESET;
      busy = 3'($random(seed));
      repeat (2) @(negedge ref_clk);
      srst = 1'b0;
      repeat (8) @(negedge ref_clk);
      rpage(8'h00, 8);
      rpage(8'hFF, 2);
      for (int c = 0; c < 3; c++)
         conv(3'(c));
      rpage(8'hF8, 6);
      wpage(dev, 8'h00, 3, 8'h5A);
      rpage(8'h00, 3);
      wpage(ADDR_BCAST, 8'h06, 1, 8'h1F);
      conv(3'h1);
      wpage(dev, 8'h00, 6, 8'hA5);
      wpage(dev, 8'h07, 1, 8'hFF);
      rpage(8'h07, 8);
      wpage(dev, 8'h06, 1, 8'h14);
      wpage(dev, 8'h00, 2, 8'h3C);
      rpage(8'h00, 2);
      wpage(dev, 8'h06, 1, 8'h1C);
      stuck(1'b1);
      wpage(dev, 8'h06, 1, 8'h18);
      stuck(1'b0);
      for (int i = 0; i < 9; i++)
      begin
         st_hi = ST[i][7:6];
         st_lo = ST[i][5:4];
         dev = {ADDR_FIXED, ST[i][3:0]};
         m.w(8);
         adr(dev, 1'b0, 1'b0);
         m.stop();
         adr({ADDR_FIXED, ST[(i + 1) % 9][3:0]}, 1'b0, 1'b1);
         m.stop();
      end
      report_and_stop();
   end
endmodule
`default_nettype wire
